// >>> logic/bacr_pkg.sv
// bacr_pkg: offsets, field positions, reset values and timing counts for the
// button algorithm control register slice.
// assumes a plain byte-wide register port from an i2c front end elsewhere.
package bacr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] LOW_POWER_SCAN_RATE_OFS   = 8'h0f;
  localparam logic [7:0] CH1_GAIN_OFS       = 8'h10;
  localparam logic [7:0] INT_ALG_CTRL_OFS   = 8'h11;
  localparam logic [7:0] CH2_GAIN_OFS       = 8'h12;

  // reset values
  localparam logic [7:0] LOW_POWER_SCAN_RATE_RST   = 8'h10;
  localparam logic [7:0] GAIN_RST           = 8'h28;
  localparam logic [7:0] INT_ALG_CTRL_RST   = 8'h18;

  // writable masks; other bits are reserved and hold reset value
  localparam logic [7:0] LOW_POWER_SCAN_RATE_WMASK = 8'h03;
  localparam logic [7:0] GAIN_WMASK         = 8'h3f;
  localparam logic [7:0] INT_ALG_CTRL_WMASK = 8'h1f;

  // control field positions
  localparam int unsigned BIT_MAXCHK_DIS    = 0;
  localparam int unsigned BIT_TIMEOUT_DIS   = 1;
  localparam int unsigned BIT_INT_POL       = 2;
  localparam int unsigned BIT_ALG_EN        = 3;
  localparam int unsigned BIT_BASE_RESTART  = 4;

  // low power scan periods in ms per rate code
  localparam int unsigned LP_PERIOD_MS_0    = 200;
  localparam int unsigned LP_PERIOD_MS_1    = 400;
  localparam int unsigned LP_PERIOD_MS_2    = 800;
  localparam int unsigned LP_PERIOD_MS_3    = 1600;

  // press timeout
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned PRESS_TIMEOUT_S   = 50;
  localparam longint unsigned PRESS_TIMEOUT_CYC = longint'(PRESS_TIMEOUT_S) * CLK_HZ;
endpackage : bacr_pkg

// >>> logic/bacr_timeout.sv
// bacr_timeout: per-channel held-press timer, raises expired when a press lasts
// past the limit and holds it until release or disable. assumes press is a synchronous level.
`timescale 1ns/1ps
module bacr_timeout #(
  parameter longint unsigned LIMIT = 64'd2000000000
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic press,
  output logic      expired
);
  logic [31:0] cnt_ff;
  logic        nxt_expired;
  logic [31:0] nxt_cnt;

  // count while held; clear on release or when disabled
  assign nxt_cnt     = (!press || !enable || expired) ? 32'h0 : cnt_ff + 32'h1;
  assign nxt_expired = press && enable && (expired || (64'(cnt_ff) + 64'd1 >= LIMIT));

  // held timer state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_ff  <= 32'h0;
      expired <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      expired <= nxt_expired;
    end
  end
endmodule : bacr_timeout

// >>> logic/bacr_regs.sv
// bacr_regs: configuration registers for low power scan rate, channel 1/2
// gain and interrupt/algorithm control, plus the pin logic they steer.
// assumes reg_* comes from an i2c slave front end on the same clock.
`timescale 1ns/1ps

module bacr_regs
  import bacr_pkg::*;
#(
  parameter int unsigned     NCH           = 4,
  parameter longint unsigned TIMEOUT_CYC   = PRESS_TIMEOUT_CYC
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [bacr_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [bacr_pkg::DATA_W-1:0]  reg_wdata,
  output logic      [bacr_pkg::DATA_W-1:0]  reg_rdata,
  output logic                              reg_hit,
  input  wire logic                         low_power_mode,
  input  wire logic [NCH-1:0]               channel_enable,
  input  wire logic [NCH-1:0]               press_detect,
  input  wire logic [NCH-1:0]               capture_done,
  input  wire logic                         error_event,
  input  wire logic                         overrange_event,
  output logic      [1:0]                   low_power_rate_code,
  output logic      [11:0]                  low_power_period_ms,
  output logic      [5:0]                   channel1_button_gain,
  output logic      [5:0]                   channel2_button_gain,
  output logic                              press_algorithm_enable,
  output logic                              raw_measurement_regs_en,
  output logic      [NCH-1:0]               baseline_reset,
  output logic                              press_state_reset,
  output logic      [NCH-1:0]               button_out,
  output logic                              interrupt_pin,
  output logic                              code_overrange_flag
);
  import bacr_pkg::*;

  logic [7:0]     lp_rate_ff;
  logic [7:0]     channel1_button_gain_ff;
  logic [7:0]     ctrl_ff;
  logic           lp_seen_ff;
  logic           mode_ff;
  logic           int_ff;
  logic           ovr_ff;
  logic [NCH-1:0] out_ff;
  logic [NCH-1:0] bl_rst_ff;
  logic           ps_rst_ff;
  logic [7:0]     channel2_button_gain_ff;
  logic [7:0]     rdata_ff;

  // address decode
  wire sel_lp    = (reg_addr == LOW_POWER_SCAN_RATE_OFS);
  wire sel_g1    = (reg_addr == CH1_GAIN_OFS);
  wire sel_ctrl  = (reg_addr == INT_ALG_CTRL_OFS);
  wire sel_g2    = (reg_addr == CH2_GAIN_OFS);
  wire wr_lp     = reg_wr && sel_lp;
  wire wr_g1     = reg_wr && sel_g1;
  wire wr_ctrl   = reg_wr && sel_ctrl;
  wire wr_g2     = reg_wr && sel_g2;

  // reserved bits merged from reset pattern
  wire [7:0] nxt_lp_rate = (reg_wdata & LOW_POWER_SCAN_RATE_WMASK) |
                           (LOW_POWER_SCAN_RATE_RST & ~LOW_POWER_SCAN_RATE_WMASK);
  wire [7:0] nxt_gain    = (reg_wdata & GAIN_WMASK) | (GAIN_RST & ~GAIN_WMASK);
  wire [7:0] nxt_ctrl    = (reg_wdata & INT_ALG_CTRL_WMASK) |
                           (INT_ALG_CTRL_RST & ~INT_ALG_CTRL_WMASK);

  // control fields
  wire alg_en      = ctrl_ff[BIT_ALG_EN];
  wire int_pol     = ctrl_ff[BIT_INT_POL];
  wire base_rst_en = ctrl_ff[BIT_BASE_RESTART];
  wire to_dis      = ctrl_ff[BIT_TIMEOUT_DIS];
  wire maxchk_dis  = ctrl_ff[BIT_MAXCHK_DIS];

  // register storage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lp_rate_ff <= LOW_POWER_SCAN_RATE_RST;
      channel1_button_gain_ff   <= GAIN_RST;
      ctrl_ff    <= INT_ALG_CTRL_RST;
      channel2_button_gain_ff   <= GAIN_RST;
    end else begin
      if (wr_lp)   lp_rate_ff <= nxt_lp_rate;
      if (wr_g1)   channel1_button_gain_ff   <= nxt_gain;
      if (wr_ctrl) ctrl_ff    <= nxt_ctrl;
      if (wr_g2)   channel2_button_gain_ff   <= nxt_gain;
    end
  end

  // read mux, unmapped reads zero
  wire [7:0] nxt_rdata = sel_lp   ? lp_rate_ff :
                         sel_g1   ? channel1_button_gain_ff   :
                         sel_ctrl ? ctrl_ff    :
                         sel_g2   ? channel2_button_gain_ff   : 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_n) rdata_ff <= 8'h00;
    else if (reg_rd) rdata_ff <= nxt_rdata;
  end
  assign reg_rdata = rdata_ff;
  assign reg_hit   = sel_lp | sel_g1 | sel_ctrl | sel_g2;

  // scan rate decode
  assign low_power_rate_code  = lp_rate_ff[1:0];
  assign low_power_period_ms  = (lp_rate_ff[1:0] == 2'h0) ? 12'(LP_PERIOD_MS_0) :
                                (lp_rate_ff[1:0] == 2'h1) ? 12'(LP_PERIOD_MS_1) :
                                (lp_rate_ff[1:0] == 2'h2) ? 12'(LP_PERIOD_MS_2) :
                                                            12'(LP_PERIOD_MS_3);
  assign channel1_button_gain   = channel1_button_gain_ff[5:0];
  assign channel2_button_gain   = channel2_button_gain_ff[5:0];
  assign press_algorithm_enable = alg_en;
  assign raw_measurement_regs_en = !alg_en;

  // power round-trip detect: normal -> low -> normal
  wire round_trip = lp_seen_ff && mode_ff && !low_power_mode;
  wire [NCH-1:0] nxt_bl_rst = (round_trip && base_rst_en) ? channel_enable
                                                          : {NCH{1'b0}};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_ff    <= 1'b0;
      lp_seen_ff <= 1'b0;
      bl_rst_ff  <= '0;
      ps_rst_ff  <= 1'b0;
    end else begin
      mode_ff    <= low_power_mode;
      lp_seen_ff <= low_power_mode ? 1'b1 : (round_trip ? 1'b0 : lp_seen_ff);
      bl_rst_ff  <= nxt_bl_rst;
      ps_rst_ff  <= round_trip;
    end
  end
  assign baseline_reset    = bl_rst_ff;
  assign press_state_reset = ps_rst_ff;

  // per-channel press timeout
  logic [NCH-1:0] expired;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_to
      bacr_timeout #(
        .LIMIT   (TIMEOUT_CYC)
      ) u_to (
        .clock   (clock),
        .rst_n   (rst_n),
        .enable  (!to_dis),
        .press   (press_detect[gi]),
        .expired (expired[gi])
      );
    end
  endgenerate

  // output pins show presses only with algorithm on
  wire [NCH-1:0] nxt_out = alg_en ? (press_detect & channel_enable & ~expired)
                                  : {NCH{1'b0}};
  // interrupt source depends on algorithm mode
  wire int_src_alg = |(nxt_out ^ out_ff);
  wire int_src_raw = |(capture_done & channel_enable) || error_event;
  wire nxt_int     = alg_en ? int_src_alg : int_src_raw;
  // overrange flag sticky until check disabled
  wire nxt_ovr     = !maxchk_dis && (ovr_ff || overrange_event);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_ff <= '0;
      int_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      int_ff <= nxt_int;
      ovr_ff <= nxt_ovr;
    end
  end
  assign button_out          = out_ff;
  assign interrupt_pin       = int_pol ? int_ff : !int_ff;
  assign code_overrange_flag = ovr_ff;

  // checks
  a_ctrl_reserved: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_ff[7:5] == 3'h0) else $error("control reserved bits changed");
  a_lp_reserved: assert property (@(posedge clock) disable iff (!rst_n)
    lp_rate_ff[7:2] == 6'h04) else $error("scan rate reserved bits changed");
  a_channel1_button_gain_write: assert property (@(posedge clock) disable iff (!rst_n)
    wr_g1 |=> channel1_button_gain_ff == {2'b00, $past(reg_wdata[5:0])}) else $error("channel1_button_gain write lost");
  a_channel2_button_gain_write: assert property (@(posedge clock) disable iff (!rst_n)
    wr_g2 |=> channel2_button_gain_ff == {2'b00, $past(reg_wdata[5:0])}) else $error("channel2_button_gain write lost");
  a_int_polarity: assert property (@(posedge clock) disable iff (!rst_n)
    interrupt_pin == (int_ff ~^ int_pol)) else $error("interrupt level wrong");
  a_raw_int: assert property (@(posedge clock) disable iff (!rst_n)
    (!alg_en && error_event && !wr_ctrl) |=> int_ff) else $error("raw interrupt missed");
  a_out_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (!alg_en && !wr_ctrl) |=> button_out == '0) else $error("output active w/o alg");
  a_ps_reset: assert property (@(posedge clock) disable iff (!rst_n)
    round_trip |=> press_state_reset) else $error("press state not reset");
  a_bl_reset: assert property (@(posedge clock) disable iff (!rst_n)
    (round_trip && base_rst_en) |=> baseline_reset == $past(channel_enable))
    else $error("baseline reset wrong");
  a_ovr_mask: assert property (@(posedge clock) disable iff (!rst_n)
    maxchk_dis |=> !code_overrange_flag) else $error("overrange not suppressed");
  a_rate_map: assert property (@(posedge clock) disable iff (!rst_n)
    (low_power_rate_code == 2'h2) |-> low_power_period_ms == 12'd800)
    else $error("rate decode wrong");
  a_to_ch0: assert property (@(posedge clock) disable iff (!rst_n)
    to_dis |=> !expired[0]) else $error("timeout while disabled");

  c_round_trip: cover property (@(posedge clock) disable iff (!rst_n) round_trip);
  c_raw_int: cover property (@(posedge clock) disable iff (!rst_n) !alg_en && int_ff);
  c_press_out: cover property (@(posedge clock) disable iff (!rst_n) |button_out);
  c_ovr: cover property (@(posedge clock) disable iff (!rst_n) code_overrange_flag);
endmodule : bacr_regs

// >>> sim/bacr_host.sv
// bacr_host: host side model issuing byte register writes and reads.
// assumes the register port of bacr_regs on the same rising clock.
`timescale 1ns/1ps
module bacr_host (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one write strobe, data scrambled once released
  // config hold bit lives outside this slice; host assumes it is set here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // read strobe, data taken once registered
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : bacr_host

// >>> sim/button_alg_ctrl_regs_tb.sv
// button_alg_ctrl_regs_tb: self-checking bench for bacr_regs.
// assumes bacr_host as the register master, short press timeout.
`timescale 1ns/1ps
module button_alg_ctrl_regs_tb;
  import bacr_pkg::*;
  logic clock, rst_n, reg_wr, reg_rd, low_power_mode, error_event, overrange_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, d;
  logic [1:0] low_power_rate_code;
  logic [11:0] low_power_period_ms;
  logic [5:0] channel1_button_gain, channel2_button_gain;
  logic [3:0] channel_enable, press_detect, capture_done, baseline_reset, button_out, acc;
  logic press_algorithm_enable, raw_measurement_regs_en, press_state_reset;
  logic interrupt_pin, code_overrange_flag, ps, seen, idle_lvl, pre;
  int n_fail, n_tests, mdl[4], msk[4];
  int unsigned r;
  bacr_host host (.clock, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  bacr_regs #(.NCH(4), .TIMEOUT_CYC(20)) dut (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_hit(), .low_power_mode, .channel_enable, .press_detect,
    .capture_done, .error_event, .overrange_event, .low_power_rate_code,
    .low_power_period_ms, .channel1_button_gain, .channel2_button_gain,
    .press_algorithm_enable, .raw_measurement_regs_en, .baseline_reset,
    .press_state_reset, .button_out, .interrupt_pin, .code_overrange_flag);
  // 40 mhz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // gather pulses and interrupt activity over a few cycles
  task automatic win(input int n);
    acc = '0;
    ps = 1'b0;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clock);
      #1;
      acc |= baseline_reset;
      ps |= press_state_reset;
      seen |= (interrupt_pin !== idle_lvl);
    end
  endtask : win
  task automatic pulse(input logic [3:0] cd, input logic er, input logic ov);
    @(posedge clock);
    capture_done <= cd;
    error_event <= er;
    overrange_event <= ov;
    @(posedge clock);
    capture_done <= '0;
    error_event <= 1'b0;
    overrange_event <= 1'b0;
    // interrupt stands right after the edge that sampled the event
    #1;
    pre = (interrupt_pin !== idle_lvl);
    win(3);
    seen |= pre;
  endtask : pulse
  // hang guard
  initial begin
    #2000000;
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    low_power_mode = 1'b0;
    error_event = 1'b0;
    overrange_event = 1'b0;
    channel_enable = 4'h5;
    press_detect = '0;
    capture_done = '0;
    idle_lvl = 1'b1;
    mdl = '{16, 40, 24, 40};
    msk = '{3, 63, 31, 63};
    r = $urandom(32'had5f2387);
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.rd(8'(8'h0f + i), rd);
      chk(rd, 16'(mdl[i]));
      d = 8'($urandom);
      host.wr(8'(8'h0f + i), d);
      mdl[i] = (mdl[i] & ~msk[i]) | (int'(d) & msk[i]);
      host.rd(8'(8'h0f + i), rd);
      chk(rd, 16'(mdl[i]));
    end
    chk(channel1_button_gain, 16'(mdl[1] & 63));
    chk(channel2_button_gain, 16'(mdl[3] & 63));
    host.wr(8'h20, 8'hff);
    host.rd(8'h20, rd);
    chk(rd, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h0f, 8'(c));
      #1;
      chk(low_power_rate_code, 16'(c));
      chk(low_power_period_ms, 16'(200 << c));
    end
    host.wr(8'h11, 8'h10);
    #1;
    chk(raw_measurement_regs_en, 16'h1);
    pulse(4'h4, 1'b0, 1'b0);
    chk(seen, 16'h1);
    pulse(4'h2, 1'b0, 1'b0);
    chk(seen, 16'h0);
    pulse(4'h0, 1'b1, 1'b0);
    chk(seen, 16'h1);
    press_detect <= 4'hf;
    win(4);
    press_detect <= 4'h0;
    chk(button_out, 16'h0);
    chk(seen, 16'h0);
    for (int b = 0; b < 2; b++) begin
      host.wr(8'h11, b ? 8'h10 : 8'h00);
      @(posedge clock);
      low_power_mode <= 1'b1;
      repeat (2) @(posedge clock);
      low_power_mode <= 1'b0;
      win(3);
      chk(acc, b ? 16'(channel_enable) : 16'h0);
      chk(ps, 16'h1);
    end
    host.wr(8'h11, 8'h14);
    idle_lvl = 1'b0;
    pulse(4'h1, 1'b0, 1'b0);
    chk(interrupt_pin, 16'h0);
    chk(seen, 16'h1);
    idle_lvl = 1'b1;
    host.wr(8'h11, 8'h18);
    press_detect <= 4'h1;
    win(3);
    chk(button_out[0], 16'h1);
    chk(seen, 16'h1);
    repeat (30) @(posedge clock);
    #1;
    chk(button_out[0], 16'h0);
    press_detect <= 4'h0;
    host.wr(8'h11, 8'h1a);
    press_detect <= 4'h1;
    repeat (35) @(posedge clock);
    #1;
    chk(button_out[0], 16'h1);
    press_detect <= 4'h0;
    pulse(4'h0, 1'b0, 1'b1);
    chk(code_overrange_flag, 16'h1);
    host.wr(8'h11, 8'h1b);
    pulse(4'h0, 1'b0, 1'b1);
    chk(code_overrange_flag, 16'h0);
    finish_test();
  end
endmodule : button_alg_ctrl_regs_tb
